/* fmbx_defs.svh */
/*
 Offsets, field positions, reset values and codes of the FPU move/branch/exception unit.
 Assumes it is included once by the unit.
*/
`ifndef FMBX_DEFS_SVH
`define FMBX_DEFS_SVH
// Register byte offsets
`define FMBX_OFS_CTRL 8'h00
`define FMBX_OFS_IRQ_STAT 8'h04
`define FMBX_OFS_IRQ_MASK 8'h08
`define FMBX_OFS_STATE 8'h0c
// Control/status register fields
`define FMBX_RM_LSB 0
`define FMBX_FLAG_LSB 2
`define FMBX_EN_LSB 7
`define FMBX_CAUSE_LSB 12
`define FMBX_CC0_BIT 23
`define FMBX_CC1_LSB 25
`define FMBX_CTRL_WMASK 32'hfe83ffff
`define FMBX_CTRL_RST 32'h00000000
// Exception bit positions within a 6-bit vector
`define FMBX_X_INEXACT 0
`define FMBX_X_UNDER 1
`define FMBX_X_OVER 2
`define FMBX_X_DIVZ 3
`define FMBX_X_INVALID 4
`define FMBX_X_UNIMPL 5
// Rounding mode codes
`define FMBX_RM_NEAR 2'h0
`define FMBX_RM_ZERO 2'h1
`define FMBX_RM_PLUS 2'h2
`define FMBX_RM_MINUS 2'h3
// Interrupt event bits
`define FMBX_EV_TRAP 0
`define FMBX_EV_LIKELY 1
`define FMBX_EV_UNDEF 2
`define FMBX_EV_W 3
`endif

/* fmbx_pkg.sv */
/*
 Types of the FPU move/branch/exception unit.
 Assumes the CPU pipeline issues one instruction record per cycle.
*/
package fmbx_pkg;
	typedef enum logic [4:0] {
		OP_NONE, OP_ARITH, OP_COMPARE,
		OP_CEIL_TO_WORD, OP_CEIL_TO_LONG, OP_FLOOR_TO_WORD, OP_FLOOR_TO_LONG,
		OP_ROUND_TO_WORD, OP_ROUND_TO_LONG, OP_CHOP_TO_WORD, OP_CHOP_TO_LONG,
		OP_FP_PLAIN_MOVE, OP_FP_MOVE_IF_CC_FALSE, OP_FP_MOVE_IF_CC_TRUE,
		OP_FP_MOVE_IF_GPR_NONZERO, OP_FP_MOVE_IF_GPR_ZERO,
		OP_BRANCH_CC_FALSE, OP_BRANCH_CC_TRUE,
		OP_BRANCH_CC_FALSE_LIKELY, OP_BRANCH_CC_TRUE_LIKELY,
		OP_GPR_MOVE_ON_CC_A, OP_GPR_MOVE_ON_CC_B
	} fmbx_op_e;
	typedef enum logic [2:0] {
		DF_NONE, DF_QNAN, DF_INF, DF_MAX_FINITE, DF_MIN_NORM, DF_ZERO
	} fmbx_dflt_e;
	// One issued instruction with datapath side results
	typedef struct packed {
		logic valid;
		fmbx_op_e op;
		logic [1:0] fmt;
		logic [4:0] fd;
		logic [2:0] cc_idx;
		logic [31:0] gpr_val;
		logic [63:0] src_val;
		logic [63:0] arith_val;
		logic cmp_true;
		logic [5:0] exc;
		logic neg;
		logic [31:0] pc;
		logic [15:0] offset;
	} fmbx_issue_s;
	// Registered outcome toward the pipeline
	typedef struct packed {
		logic valid;
		logic wr_en;
		logic [4:0] fd;
		logic [63:0] data;
		logic undef;
		logic trap;
		logic br_taken;
		logic nullify;
		logic [31:0] target;
		logic cc_val;
		fmbx_dflt_e dflt;
		logic dflt_neg;
	} fmbx_result_s;
endpackage

/* fmbx_unit.sv */
/*
 FPU move, branch and exception unit with an AHB-Lite register slave.
 Assumes the arithmetic datapath reports raw conditions and values with each issue.
*/
`timescale 1ns/10ps
`include "fmbx_defs.svh"
module fmbx_unit (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire fmbx_pkg::fmbx_issue_s issue,
	output fmbx_pkg::fmbx_result_s result,
	output logic [1:0] round_mode,
	output logic irq
);
	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Keep one condition; inexact may ride with overflow or underflow
	function automatic logic [5:0] one_cond(input logic [5:0] x);
		logic [5:0] r;
		r = 6'h00;
		if (x[`FMBX_X_UNIMPL]) r[`FMBX_X_UNIMPL] = 1'b1;
		else if (x[`FMBX_X_INVALID]) r[`FMBX_X_INVALID] = 1'b1;
		else if (x[`FMBX_X_DIVZ]) r[`FMBX_X_DIVZ] = 1'b1;
		else if (x[`FMBX_X_OVER]) r = x & 6'h05;
		else if (x[`FMBX_X_UNDER]) r = x & 6'h03;
		else r = x & 6'h01;
		return r;
	endfunction
	// Trap test of a cause against enables; unimplemented always traps
	function automatic logic traps(input logic [5:0] c, input logic [4:0] en);
		return c[`FMBX_X_UNIMPL] | (|(c[4:0] & en));
	endfunction
	// Whether an opcode is a conversion or arithmetic that rewrites cause
	function automatic logic is_arith(input fmbx_pkg::fmbx_op_e op);
		return op inside {fmbx_pkg::OP_ARITH, fmbx_pkg::OP_COMPARE,
			fmbx_pkg::OP_CEIL_TO_WORD, fmbx_pkg::OP_CEIL_TO_LONG,
			fmbx_pkg::OP_FLOOR_TO_WORD, fmbx_pkg::OP_FLOOR_TO_LONG,
			fmbx_pkg::OP_ROUND_TO_WORD, fmbx_pkg::OP_ROUND_TO_LONG,
			fmbx_pkg::OP_CHOP_TO_WORD, fmbx_pkg::OP_CHOP_TO_LONG};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [1:0] rm_q, rm_d;
	logic [4:0] flag_q, flag_d;
	logic [4:0] en_q, en_d;
	logic [5:0] cause_q, cause_d;
	logic [7:0] cc_q, cc_d;
	logic [1:0] ftag_q [32];
	logic [1:0] ftag_d [32];
	logic [`FMBX_EV_W-1:0] ist_q, ist_d, imask_q, imask_d;
	logic [15:0] trap_cnt_q, trap_cnt_d;
	fmbx_pkg::fmbx_result_s res_q, res_d;
	logic ph_wr_q, ph_wr_d, ph_act_q, ph_act_d;
	logic [7:0] ph_ofs_q, ph_ofs_d;
	logic [31:0] rdat_q, rdat_d;
	logic [31:0] ctrl_rd;
	logic addr_ok;
	logic bus_wr;
	logic [`FMBX_EV_W-1:0] ev;
	logic [5:0] xc;
	logic trap_now;
	logic cc_sel;

	// Assembled control/status word; code 0 apart from codes 1-7
	always_comb begin
		ctrl_rd = 32'h00000000;
		ctrl_rd[`FMBX_RM_LSB +: 2] = rm_q;
		ctrl_rd[`FMBX_FLAG_LSB +: 5] = flag_q;
		ctrl_rd[`FMBX_EN_LSB +: 5] = en_q;
		ctrl_rd[`FMBX_CAUSE_LSB +: 6] = cause_q;
		ctrl_rd[`FMBX_CC0_BIT] = cc_q[0];
		ctrl_rd[`FMBX_CC1_LSB +: 7] = cc_q[7:1];
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdat_q;
	assign addr_ok = hsel & hready & htrans[1];
	assign bus_wr = ph_act_q & ph_wr_q & (ph_ofs_q == `FMBX_OFS_CTRL);

	// Address phase capture; read data latched for the data phase
	always_comb begin
		ph_act_d = addr_ok;
		ph_wr_d = hwrite;
		ph_ofs_d = haddr[7:0];
		rdat_d = 32'h00000000;
		if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				`FMBX_OFS_CTRL: rdat_d = ctrl_rd;
				`FMBX_OFS_IRQ_STAT: rdat_d = {29'h0, ist_q};
				`FMBX_OFS_IRQ_MASK: rdat_d = {29'h0, imask_q};
				`FMBX_OFS_STATE: rdat_d = {16'h0, trap_cnt_q};
				default: rdat_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_act_q <= 1'b0;
			ph_wr_q <= 1'b0;
			ph_ofs_q <= 8'h00;
			rdat_q <= 32'h00000000;
		end else begin
			ph_act_q <= ph_act_d;
			ph_wr_q <= ph_wr_d;
			ph_ofs_q <= ph_ofs_d;
			rdat_q <= rdat_d;
		end
	end

	// ----------------------------------------------------------------
	// Rounding direction toward the datapath
	// ----------------------------------------------------------------
	always_comb begin
		case (issue.op)
			fmbx_pkg::OP_CEIL_TO_WORD, fmbx_pkg::OP_CEIL_TO_LONG:
				round_mode = `FMBX_RM_PLUS;
			fmbx_pkg::OP_FLOOR_TO_WORD, fmbx_pkg::OP_FLOOR_TO_LONG:
				round_mode = `FMBX_RM_MINUS;
			fmbx_pkg::OP_ROUND_TO_WORD, fmbx_pkg::OP_ROUND_TO_LONG:
				round_mode = `FMBX_RM_NEAR;
			fmbx_pkg::OP_CHOP_TO_WORD, fmbx_pkg::OP_CHOP_TO_LONG:
				round_mode = `FMBX_RM_ZERO;
			default: round_mode = rm_q;
		endcase
	end

	// ----------------------------------------------------------------
	// Instruction execution
	// ----------------------------------------------------------------
	assign cc_sel = cc_q[issue.cc_idx];
	assign xc = one_cond(issue.exc);
	assign trap_now = issue.valid & is_arith(issue.op) & traps(xc, en_q);

	always_comb begin
		rm_d = rm_q;
		flag_d = flag_q;
		en_d = en_q;
		cause_d = cause_q;
		cc_d = cc_q;
		ftag_d = ftag_q;
		ev = '0;
		res_d = '0;
		res_d.valid = issue.valid;
		res_d.fd = issue.fd;
		res_d.target = issue.pc + 32'h4 + {{14{issue.offset[15]}}, issue.offset, 2'b00};
		// Software write of the control/status word
		if (bus_wr) begin
			rm_d = hwdata[`FMBX_RM_LSB +: 2];
			flag_d = hwdata[`FMBX_FLAG_LSB +: 5];
			en_d = hwdata[`FMBX_EN_LSB +: 5];
			cause_d = hwdata[`FMBX_CAUSE_LSB +: 6];
			cc_d = {hwdata[`FMBX_CC1_LSB +: 7], hwdata[`FMBX_CC0_BIT]};
			res_d.trap = traps(hwdata[`FMBX_CAUSE_LSB +: 6], hwdata[`FMBX_EN_LSB +: 5]);
		end
		if (issue.valid) begin
			if (is_arith(issue.op)) begin
				cause_d = xc;
				if (trap_now) begin
					res_d.trap = 1'b1;
				end else begin
					flag_d = flag_d | xc[4:0];
					res_d.wr_en = (issue.op != fmbx_pkg::OP_COMPARE);
					res_d.data = issue.arith_val;
					res_d.dflt_neg = issue.neg;
					// Default result by condition and mode
					if (xc[`FMBX_X_INVALID]) begin
						res_d.dflt = fmbx_pkg::DF_QNAN;
					end else if (xc[`FMBX_X_DIVZ]) begin
						res_d.dflt = fmbx_pkg::DF_INF;
					end else if (xc[`FMBX_X_OVER]) begin
						case (rm_q)
							`FMBX_RM_NEAR: res_d.dflt = fmbx_pkg::DF_INF;
							`FMBX_RM_ZERO: res_d.dflt = fmbx_pkg::DF_MAX_FINITE;
							`FMBX_RM_PLUS: res_d.dflt = issue.neg ?
								fmbx_pkg::DF_MAX_FINITE : fmbx_pkg::DF_INF;
							default: res_d.dflt = issue.neg ?
								fmbx_pkg::DF_INF : fmbx_pkg::DF_MAX_FINITE;
						endcase
					end else if (xc[`FMBX_X_UNDER]) begin
						res_d.dflt = (rm_q == `FMBX_RM_PLUS && !issue.neg) ?
							fmbx_pkg::DF_MIN_NORM : fmbx_pkg::DF_ZERO;
						if (rm_q == `FMBX_RM_PLUS && issue.neg) res_d.dflt_neg = 1'b0;
						if (rm_q == `FMBX_RM_MINUS) res_d.dflt_neg = 1'b1;
					end
					if (issue.op == fmbx_pkg::OP_COMPARE) begin
						cc_d[issue.cc_idx] = issue.cmp_true;
					end
					if (res_d.wr_en) ftag_d[issue.fd] = issue.fmt;
				end
			end else begin
				case (issue.op)
					fmbx_pkg::OP_FP_PLAIN_MOVE: res_d.wr_en = 1'b1;
					fmbx_pkg::OP_FP_MOVE_IF_CC_FALSE: res_d.wr_en = !cc_sel;
					fmbx_pkg::OP_FP_MOVE_IF_CC_TRUE: res_d.wr_en = cc_sel;
					fmbx_pkg::OP_FP_MOVE_IF_GPR_NONZERO:
						res_d.wr_en = (issue.gpr_val != 32'h0);
					fmbx_pkg::OP_FP_MOVE_IF_GPR_ZERO:
						res_d.wr_en = (issue.gpr_val == 32'h0);
					fmbx_pkg::OP_BRANCH_CC_FALSE: res_d.br_taken = !cc_sel;
					fmbx_pkg::OP_BRANCH_CC_TRUE: res_d.br_taken = cc_sel;
					fmbx_pkg::OP_BRANCH_CC_FALSE_LIKELY: begin
						res_d.br_taken = !cc_sel;
						res_d.nullify = cc_sel;
						ev[`FMBX_EV_LIKELY] = 1'b1;
					end
					fmbx_pkg::OP_BRANCH_CC_TRUE_LIKELY: begin
						res_d.br_taken = cc_sel;
						res_d.nullify = !cc_sel;
						ev[`FMBX_EV_LIKELY] = 1'b1;
					end
					fmbx_pkg::OP_GPR_MOVE_ON_CC_A: res_d.cc_val = !cc_sel;
					fmbx_pkg::OP_GPR_MOVE_ON_CC_B: res_d.cc_val = cc_sel;
					default: res_d.wr_en = 1'b0;
				endcase
				res_d.data = issue.src_val;
				// Conditional moves retag the destination with their format
				if (issue.op inside {fmbx_pkg::OP_FP_MOVE_IF_CC_FALSE,
					fmbx_pkg::OP_FP_MOVE_IF_CC_TRUE, fmbx_pkg::OP_FP_MOVE_IF_GPR_NONZERO,
					fmbx_pkg::OP_FP_MOVE_IF_GPR_ZERO}) begin
					res_d.undef = !res_d.wr_en && (ftag_q[issue.fd] != issue.fmt);
					ev[`FMBX_EV_UNDEF] = res_d.undef;
					ftag_d[issue.fd] = issue.fmt;
				end else if (res_d.wr_en) begin
					ftag_d[issue.fd] = issue.fmt;
				end
			end
		end
		ev[`FMBX_EV_TRAP] = res_d.trap;
	end

	// ----------------------------------------------------------------
	// Interrupt status, mask and trap count
	// ----------------------------------------------------------------
	always_comb begin
		ist_d = ist_q;
		imask_d = imask_q;
		trap_cnt_d = trap_cnt_q + {15'h0, ev[`FMBX_EV_TRAP]};
		if (ph_act_q && ph_wr_q && ph_ofs_q == `FMBX_OFS_IRQ_STAT)
			ist_d = ist_q & ~hwdata[`FMBX_EV_W-1:0];
		if (ph_act_q && ph_wr_q && ph_ofs_q == `FMBX_OFS_IRQ_MASK)
			imask_d = hwdata[`FMBX_EV_W-1:0];
		ist_d = ist_d | ev; // Set wins over clear
	end

	assign irq = |(ist_q & imask_q);
	assign result = res_q;

	// Registers of all groups but the bus phase and the format tags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rm_q <= 2'(`FMBX_CTRL_RST);
			flag_q <= 5'h00;
			en_q <= 5'h00;
			cause_q <= 6'h00;
			cc_q <= 8'h00;
			ist_q <= '0;
			imask_q <= '0;
			trap_cnt_q <= 16'h0000;
			res_q <= '0;
		end else begin
			rm_q <= rm_d;
			flag_q <= flag_d;
			en_q <= en_d;
			cause_q <= cause_d;
			cc_q <= cc_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			trap_cnt_q <= trap_cnt_d;
			res_q <= res_d;
		end
	end

	// Format tag per FPU general register
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_tag
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) ftag_q[gi] <= 2'h0;
				else ftag_q[gi] <= ftag_d[gi];
			end
		end
	endgenerate
endmodule

/* fmbx_unit_sva.sv */
/*
 Port checks of the FPU move/branch/exception unit.
 Assumes a bind onto fmbx_unit from the bench top file.
*/
`timescale 1ns/10ps
module fmbx_unit_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire fmbx_pkg::fmbx_issue_s issue,
	input wire fmbx_pkg::fmbx_result_s result,
	input wire logic [1:0] round_mode
);
	// ---
	// Checks
	// ---
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// True compare, then one idle cycle
	sequence s_cmp;
		issue.valid && issue.op == fmbx_pkg::OP_COMPARE && issue.cmp_true ##1 !issue.valid;
	endsequence
	// Issue of o on the code the compare wrote
	sequence s_same(o);
		issue.valid && issue.op == o && issue.cc_idx == $past(issue.cc_idx, 2);
	endsequence
	AST_UP: assert property (
		issue.op inside {fmbx_pkg::OP_CEIL_TO_WORD, fmbx_pkg::OP_CEIL_TO_LONG} |-> round_mode == 2'h2)
		else $error("ceiling not rounding up");
	AST_CHOP: assert property (
		issue.op inside {fmbx_pkg::OP_CHOP_TO_WORD, fmbx_pkg::OP_CHOP_TO_LONG} |-> round_mode == 2'h1)
		else $error("chop not rounding to zero");
	AST_LAT: assert property (1'b1 |=> result.valid == $past(issue.valid))
		else $error("result valid not one cycle after issue");
	AST_MOVE: assert property (
		issue.valid && issue.op == fmbx_pkg::OP_FP_PLAIN_MOVE
		|=> result.wr_en && result.data == $past(issue.src_val))
		else $error("plain move lost");
	AST_TARGET: assert property (
		issue.valid && issue.op inside {[fmbx_pkg::OP_BRANCH_CC_FALSE:fmbx_pkg::OP_BRANCH_CC_TRUE_LIKELY]}
		|=> result.target == $past(issue.pc) + 32'h4
		+ {{14{$past(issue.offset[15])}}, $past(issue.offset), 2'b00})
		else $error("branch target wrong");
	AST_TAKEN: assert property (
		s_cmp ##1 s_same(fmbx_pkg::OP_BRANCH_CC_TRUE) |=> result.br_taken)
		else $error("branch on true code not taken");
	AST_SLOT: assert property (
		issue.valid && issue.op inside {fmbx_pkg::OP_BRANCH_CC_FALSE, fmbx_pkg::OP_BRANCH_CC_TRUE}
		|=> !result.nullify)
		else $error("ordinary branch nullified its slot");
	AST_NULL: assert property (
		issue.valid && issue.op inside {fmbx_pkg::OP_BRANCH_CC_FALSE_LIKELY,
		fmbx_pkg::OP_BRANCH_CC_TRUE_LIKELY} |=> result.nullify == !result.br_taken)
		else $error("likely branch slot handling wrong");
	AST_CCSEL: assert property (
		s_cmp ##1 s_same(fmbx_pkg::OP_GPR_MOVE_ON_CC_B) |=> result.cc_val)
		else $error("selected code not supplied");
	AST_UNIMPL: assert property (
		issue.valid && issue.op == fmbx_pkg::OP_ARITH && issue.exc[5] |=> result.trap && !result.wr_en)
		else $error("unimplemented operation did not trap");
	AST_DIVZ: assert property (
		issue.valid && issue.op == fmbx_pkg::OP_ARITH && issue.exc == 6'h08
		|=> result.trap || result.dflt == fmbx_pkg::DF_INF)
		else $error("divide by zero default wrong");
endmodule

/* fmbx_cpu_model.sv */
/*
 Host pipeline model issuing instruction records.
 Assumes the unit answers one cycle after taking a record.
*/
`timescale 1ns/10ps
module fmbx_cpu_model (
	input wire logic hclk,
	output fmbx_pkg::fmbx_issue_s issue
);
	// ---
	// Issue
	// ---
	initial issue = '0;
	// Format carried by each record; the bench may change it
	logic [1:0] fmt_sel = 2'h1;
	// One record after an edge, valid dropped at the taking edge
	task automatic send(input fmbx_pkg::fmbx_op_e op, input logic [2:0] cc, input logic ct,
		input logic [5:0] x, input logic [63:0] v);
		fmbx_pkg::fmbx_issue_s r;
		r = '0;
		r.valid = 1'b1;
		r.op = op;
		r.fmt = fmt_sel;
		r.cc_idx = cc;
		r.cmp_true = ct;
		r.exc = x;
		r.src_val = v;
		r.arith_val = v;
		r.pc = 32'h100;
		r.offset = 16'hfffe;
		@(posedge hclk);
		issue <= r;
		@(posedge hclk);
		issue.valid <= 1'b0;
		#1;
	endtask
endmodule

/* test_fmbx_unit.sv */
/*
 Self-checking bench of the FPU move/branch/exception unit.
 Assumes package, unit, host model and checker compiled first.
*/
`timescale 1ns/10ps
module test_fmbx_unit;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0] round_mode;
	logic irq;
	logic tk;
	logic [7:0] rmt = 8'h4e;
	fmbx_pkg::fmbx_issue_s issue;
	fmbx_pkg::fmbx_result_s result;
	fmbx_pkg::fmbx_result_s res;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 hclk = ~hclk;
	fmbx_cpu_model cpu (.hclk(hclk), .issue(issue));
	fmbx_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue(issue),
		.result(result), .round_mode(round_mode), .irq(irq));
	// ---
	// Tasks
	// ---
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One AHB-Lite single transfer, read data taken at the data phase end
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("response", 64'h0, 64'(hresp));
		#1;
	endtask
	// Arithmetic issue, then control readback
	task automatic arith(input logic [5:0] x, input logic [31:0] exp);
		cpu.send(fmbx_pkg::OP_ARITH, 3'h0, 1'b0, x, 64'h5);
		res = result;
		bus(1'b0, 32'h0, 32'h0);
		check("control", 64'(exp), 64'(rd));
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	// ---
	// Tests
	// ---
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, 32'h10, 32'hffffffff);
		for (int a = 0; a < 20; a += 4) begin
			bus(1'b0, 32'(a), 32'h0);
			check("reset value", 64'h0, 64'(rd));
		end
		bus(1'b1, 32'h0, 32'h3);
		check("round mode", 64'h3, 64'(round_mode));
		for (int i = 0; i < 8; i++) begin
			cpu.send(fmbx_pkg::fmbx_op_e'(5'(3 + i)), 3'h0, 1'b0, 6'h0, 64'h0);
			check("directed", 64'(rmt[i / 2 * 2 +: 2]), 64'(round_mode));
		end
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			cpu.send(fmbx_pkg::OP_COMPARE, 3'(k), 1'b1, 6'h0, 64'h0);
		end
		bus(1'b0, 32'h0, 32'h0);
		check("codes", 64'hfe800003, 64'(rd));
		for (int s = 3; s < 6; s += 2) begin
			for (int j = 0; j < 6; j++) begin
				cpu.send(fmbx_pkg::OP_COMPARE, 3'(s), s == 3, 6'h0, 64'h0);
				cpu.send(fmbx_pkg::fmbx_op_e'(5'(16 + j)), 3'(s), 1'b0, 6'h0, 64'h0);
				tk = (j % 2 == 1) == (s == 3);
				if (j < 4) begin
					check("taken", 64'(tk), 64'(result.br_taken));
					check("nullify", 64'(j > 1 && !tk), 64'(result.nullify));
					check("target", 64'h0fc, 64'(result.target));
				end else begin
					check("code", 64'((j == 5) == (s == 3)), 64'(result.cc_val));
				end
			end
		end
		$display("test branches done");
		bus(1'b1, 32'h8, 32'h1);
		arith(6'h08, 32'hde808023);
		check("divz default", 64'(fmbx_pkg::DF_INF), 64'(res.dflt));
		arith(6'h00, 32'hde800023);
		bus(1'b1, 32'h0, 32'hde800403);
		arith(6'h08, 32'hde808403);
		check("trap", 64'h0, 64'(res.wr_en));
		repeat (2) @(posedge hclk);
		check("irq", 64'h1, 64'(irq));
		bus(1'b1, 32'h8, 32'h0);
		repeat (2) @(posedge hclk);
		check("irq masked", 64'h0, 64'(irq));
		bus(1'b0, 32'h4, 32'h0);
		check("events", 64'h3, 64'(rd));
		bus(1'b1, 32'h4, 32'h3);
		bus(1'b0, 32'h4, 32'h0);
		check("events cleared", 64'h0, 64'(rd));
		arith(6'h20, 32'hde820403);
		check("unimpl trap", 64'h1, 64'(res.trap));
		bus(1'b0, 32'hc, 32'h0);
		check("trap count", 64'h2, 64'(rd));
		bus(1'b1, 32'h0, 32'hde800003);
		arith(6'h05, 32'hde805017);
		check("over default", 64'(fmbx_pkg::DF_MAX_FINITE), 64'(res.dflt));
		arith(6'h18, 32'hde810057);
		check("invalid default", 64'(fmbx_pkg::DF_QNAN), 64'(res.dflt));
		arith(6'h03, 32'hde80305f);
		check("under default", 64'(fmbx_pkg::DF_ZERO), 64'(res.dflt));
		check("under sign", 64'h1, 64'(res.dflt_neg));
		bus(1'b1, 32'h0, 32'hde808403);
		bus(1'b0, 32'hc, 32'h0);
		check("write trap", 64'h3, 64'(rd));
		$display("test exceptions done");
		cpu.send(fmbx_pkg::OP_FP_PLAIN_MOVE, 3'h0, 1'b0, 6'h0, 64'h1234);
		check("move data", 64'h1234, result.data);
		cpu.send(fmbx_pkg::OP_FP_MOVE_IF_GPR_NONZERO, 3'h0, 1'b0, 6'h0, 64'h1);
		check("move skipped", 64'h0, 64'(result.wr_en));
		cpu.send(fmbx_pkg::OP_FP_MOVE_IF_GPR_ZERO, 3'h0, 1'b0, 6'h0, 64'h1);
		check("move made", 64'h1, 64'(result.wr_en));
		cpu.fmt_sel = 2'h2;
		cpu.send(fmbx_pkg::OP_FP_MOVE_IF_GPR_NONZERO, 3'h0, 1'b0, 6'h0, 64'h1);
		check("undefined", 64'h1, 64'(result.undef));
		cpu.send(fmbx_pkg::OP_FP_MOVE_IF_GPR_NONZERO, 3'h0, 1'b0, 6'h0, 64'h1);
		check("retagged", 64'h0, 64'(result.undef));
		bus(1'b0, 32'h4, 32'h0);
		check("undef event", 64'h5, 64'(rd));
		$display("test moves done");
		wrap_up();
	end
endmodule
bind fmbx_unit fmbx_unit_chk chk (.hclk(hclk), .hresetn(hresetn), .issue(issue),
	.result(result), .round_mode(round_mode));
